// ### rtl/sar_adc_pkg.sv
// Constants for the successive-approximation converter sequencer
package sar_adc_pkg;
   // Register addresses in the device memory map
   localparam logic [15:0] RESULT_ADDR     = 16'h0070;
   localparam logic [15:0] CTRL_ADDR       = 16'h0071;
   // Interrupt block, offsets of our own
   localparam logic [15:0] IRQ_STATUS_ADDR = 16'h0072;
   localparam logic [15:0] IRQ_ENABLE_ADDR = 16'h0073;
   localparam logic [15:0] IRQ_CLEAR_ADDR  = 16'h0074;
   // Control register fields
   localparam int          DONE_BIT        = 7;
   localparam int          ON_BIT          = 5;
   localparam int          CHAN_MSB        = 3;
   localparam logic [7:0]  CTRL_RESET      = 8'h00;
   localparam logic [7:0]  RESULT_RESET    = 8'h00;
   localparam logic [7:0]  CTRL_WR_MASK    = 8'h2f;
   // Status event bits
   localparam int          EV_DONE_BIT     = 0;
   localparam int          EV_ABORT_BIT    = 1;
   localparam int          EV_WIDTH        = 2;
   // Timing: converter clock is clk/2, conversion 12 converter periods
   localparam int          CLK_DIV         = 2;
   localparam int          CONV_PERIODS    = 12;
   localparam int          SAR_STEPS       = 8;
   localparam int          SAMPLE_PERIODS  = CONV_PERIODS - SAR_STEPS;
   localparam logic [4:0]  CONV_CYCLES     = 5'(CONV_PERIODS * CLK_DIV);
   localparam logic [4:0]  SAMPLE_CYCLES   = 5'(SAMPLE_PERIODS * CLK_DIV);

   typedef enum logic [1:0] {
      ST_OFF    = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_SAR    = 2'b10
   } seq_state_t;
endpackage

// ### rtl/sar_adc_sequencer.sv
// Sequencer for the 8-bit successive-approximation converter
`timescale 1ns/100ps

// Functional notes
// - Full-scale input gives FFh, zero gives 00h
// - Sample phase, then 8 approximation cycles
// - Conversions repeat while converter is on
// - Conversion lasts 12 half-rate converter periods
// - Four-bit field selects channel 0 to 15
// - Converter-on bit starts continuous conversion
// - Done flag set per conversion; end also sets IRQ status bit 0
// - Result held until next conversion ends
// - Control write with on bit set restarts conversion
// - Result read or control write clears flag
// - Clearing on bit stops, saves power
// - Wait mode leaves converter running
// - Halt mode disables the converter
// - Result register read-only, resets 00h
// - Result at 0070h, control at 0071h
module sar_adc_sequencer
   import sar_adc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [7:0]  rdata_o,
   input  wire logic        comp_above_i,
   input  wire logic        halt_mode_i,
   input  wire logic        wait_mode_i,
   output logic      [3:0]  mux_sel_o,
   output logic             sample_o,
   output logic      [7:0]  dac_code_o,
   output logic             analog_on_o,
   output logic             irq_o
);

   seq_state_t  state_reg;
   seq_state_t  state_next;
   logic [7:0]  ctrl_reg;
   logic [7:0]  result_reg;
   logic [7:0]  trial_reg;
   logic [7:0]  trial_next;
   logic [2:0]  bit_reg;
   logic [2:0]  bit_next;
   logic [4:0]  cnt_reg;
   logic [4:0]  cnt_next;
   logic [3:0]  chan_reg;
   logic        done_reg;
   logic [7:0]  rdata_reg;
   logic [EV_WIDTH-1:0] ev_status_reg;
   logic [EV_WIDTH-1:0] ev_enable_reg;
   logic        comp_reg;

   wire         ctrl_wr     = wr_i && (addr_i == CTRL_ADDR);
   wire         result_rd   = rd_i && (addr_i == RESULT_ADDR);
   wire         ctrl_rd     = rd_i && (addr_i == CTRL_ADDR);
   wire         status_rd   = rd_i && (addr_i == IRQ_STATUS_ADDR);
   wire         enable_rd   = rd_i && (addr_i == IRQ_ENABLE_ADDR);
   wire         enable_wr   = wr_i && (addr_i == IRQ_ENABLE_ADDR);
   wire         clear_wr    = wr_i && (addr_i == IRQ_CLEAR_ADDR);
   wire         conv_on     = ctrl_reg[ON_BIT] && !halt_mode_i;
   // abort and restart
   // Halt wins: a write in halt only arms the on bit
   wire         restart     = ctrl_wr && wdata_i[ON_BIT] && !halt_mode_i;
   wire         half_tick   = cnt_reg[0];
   wire         sar_step    = (state_reg == ST_SAR) && half_tick;
   wire         last_step   = sar_step && (bit_reg == 3'd0);
   // comparator decides each bit; full scale settles at FFh
   wire [7:0]   bit_mask    = 8'h01 << bit_reg;
   wire [7:0]   kept_trial  = comp_reg ? trial_reg : (trial_reg & ~bit_mask);
   wire [7:0]   final_code  = kept_trial;
   wire         conv_end    = last_step && !restart && conv_on;
   wire [EV_WIDTH-1:0] ev_set;
   wire [EV_WIDTH-1:0] ev_clr  = clear_wr ? wdata_i[EV_WIDTH-1:0] : '0;
   wire [7:0]   ctrl_view   = {done_reg, 1'b0, ctrl_reg[ON_BIT], 1'b0, ctrl_reg[CHAN_MSB:0]};
   wire [7:0]   rdata_next  = result_rd ? result_reg :
                              ctrl_rd   ? ctrl_view :
                              status_rd ? 8'(ev_status_reg) :
                              enable_rd ? 8'(ev_enable_reg) : 8'h00;

   assign ev_set[EV_DONE_BIT]  = conv_end;
   assign ev_set[EV_ABORT_BIT] = restart && (state_reg != ST_OFF);

   // Sequencer next state
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg + 5'd1;
      trial_next = trial_reg;
      bit_next   = bit_reg;
      case (state_reg)
         ST_OFF: begin
            cnt_next = 5'd0;
         end
         ST_SAMPLE: begin
            if (cnt_reg == SAMPLE_CYCLES - 5'd1) begin
               state_next = ST_SAR;
               trial_next = 8'h80;
               bit_next   = 3'd7;
            end
         end
         ST_SAR: begin
            // one bit per converter period, MSB first
            if (sar_step) begin
               trial_next = kept_trial | (bit_mask >> 1);
               bit_next   = bit_reg - 3'd1;
               if (bit_reg == 3'd0) begin
                  // back to sampling after 12 periods
                  state_next = ST_SAMPLE;
                  cnt_next   = 5'd0;
               end
            end
         end
         default: begin
            state_next = ST_OFF;
         end
      endcase
      if (restart || (conv_on && state_reg == ST_OFF)) begin
         state_next = ST_SAMPLE;
         cnt_next   = 5'd0;
      end
      if (!conv_on && !restart) begin
         state_next = ST_OFF;
         cnt_next   = 5'd0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg <= ST_OFF;
         cnt_reg   <= 5'd0;
         trial_reg <= 8'h00;
         bit_reg   <= 3'd0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         trial_reg <= trial_next;
         bit_reg   <= bit_next;
      end
   end

   // channel and on bit writable, reserved bits forced low
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_reg <= CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_reg <= wdata_i & CTRL_WR_MASK;
      end
   end

   // channel latched only as sampling begins
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         chan_reg <= 4'h0;
      end else if (restart || (state_next == ST_SAMPLE && state_reg != ST_SAMPLE)) begin
         chan_reg <= restart ? wdata_i[CHAN_MSB:0] : ctrl_reg[CHAN_MSB:0];
      end
   end

   // result changes only at conversion end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         result_reg <= RESULT_RESET;
      end else if (conv_end) begin
         result_reg <= final_code;
      end
   end

   // done flag; a finishing conversion wins over a read
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         done_reg <= 1'b0;
      end else if (conv_end) begin
         done_reg <= 1'b1;
      end else if (result_rd || ctrl_wr) begin
         done_reg <= 1'b0;
      end
   end

   // Comparator follows our own trial code on this clock, so one stage;
   // a three-stage synchroniser would outlast the two-cycle bit
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         comp_reg <= 1'b0;
      end else begin
         comp_reg <= comp_above_i;
      end
   end

   // Interrupt status: set beats clear
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ev_status_reg <= '0;
         ev_enable_reg <= '0;
      end else begin
         ev_status_reg <= (ev_status_reg & ~ev_clr) | ev_set;
         if (enable_wr) begin
            ev_enable_reg <= wdata_i[EV_WIDTH-1:0];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // wait mode is not a gating term
   assign rdata_o     = rdata_reg;
   assign mux_sel_o   = chan_reg;
   assign sample_o    = (state_reg == ST_SAMPLE);
   assign dac_code_o  = trial_reg;
   assign analog_on_o = conv_on;
   // conversion end and abort raise irq_o once enabled; enable defaults off
   assign irq_o       = |(ev_status_reg & ev_enable_reg);

   wire unused_wait = wait_mode_i;
endmodule

// ### tb/analog_front_model.sv
// Analog input mux, hold capacitor and comparator
`timescale 1ns/100ps
module analog_front_model (
   input  wire logic       clk_i,
   input  wire logic [3:0] mux_sel_i,
   input  wire logic       sample_i,
   input  wire logic [7:0] dac_code_i,
   output logic            comp_above_o
);
   logic [7:0] held_reg;
   wire logic [7:0] pin_level = (mux_sel_i == 4'hf) ? 8'hff :
                                (mux_sel_i == 4'h0) ? 8'h00 : {mux_sel_i, 4'h9};
   always_ff @(posedge clk_i) if (sample_i) held_reg <= pin_level;
   assign comp_above_o = (held_reg >= dac_code_i);
endmodule

// ### tb/sar_adc_sequencer_assertions.sv
// Port-level checks for the converter sequencer
`timescale 1ns/100ps
module sar_adc_sequencer_assertions
   import sar_adc_pkg::*;
(
   input logic        clk_i,
   input logic        rst_b_i,
   input logic [15:0] addr_i,
   input logic [7:0]  wdata_i,
   input logic        wr_i,
   input logic        rd_i,
   input logic [7:0]  rdata_o,
   input logic        halt_mode_i,
   input logic [3:0]  mux_sel_o,
   input logic        sample_o,
   input logic [7:0]  dac_code_o,
   input logic        analog_on_o
);
   default clocking dc @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   chk_conv_len: assert property (disable iff (!rst_b_i || wr_i || halt_mode_i || !analog_on_o)
      $rose(sample_o) |-> sample_o[*8] ##1 !sample_o[*8] ##9 sample_o) else $error("bad period");
   chk_sar_msb: assert property ($fell(sample_o) && analog_on_o
      |-> ##[0:1] dac_code_o == 8'h80) else $error("first trial not msb");
   chk_mux_hold: assert property (!sample_o |-> $stable(mux_sel_o))
      else $error("channel moved outside sampling");
   chk_off_quiet: assert property (!analog_on_o ##1 !analog_on_o |-> !sample_o)
      else $error("sampling while off");
   chk_halt_off: assert property (halt_mode_i |-> !analog_on_o ##1 !sample_o)
      else $error("powered in halt");
   chk_ctrl_resv: assert property ($past(rd_i && addr_i == CTRL_ADDR)
      |-> !rdata_o[6] && !rdata_o[4]) else $error("reserved bit set");
   chk_unmapped_rd: assert property ($past(rd_i) && ($past(addr_i) < RESULT_ADDR ||
      $past(addr_i) > IRQ_CLEAR_ADDR) |-> rdata_o == 8'h00) else $error("unmapped data");
   chk_write_restart: assert property ($past(wr_i && addr_i == CTRL_ADDR && wdata_i[ON_BIT]
      && !halt_mode_i) && !halt_mode_i |-> analog_on_o && sample_o) else $error("no restart");
   cover property ($fell(sample_o) && analog_on_o);
   cover property (halt_mode_i && $past(sample_o));
   cover property ($past(rd_i && addr_i == RESULT_ADDR) && rdata_o == 8'hff);
endmodule
bind sar_adc_sequencer sar_adc_sequencer_assertions u_chk (.*);

// ### tb/sar_adc_sequencer_tb.sv
// Register-level bench for the converter sequencer
`timescale 1ns/100ps
module sar_adc_sequencer_tb
   import sar_adc_pkg::*;
;
   logic        clk_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic [15:0] addr_i = 16'h0000;
   logic [7:0]  wdata_i = 8'h00;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic        halt_mode_i = 1'b0;
   logic        wait_mode_i = 1'b1;
   logic [7:0]  rdata_o, dac_code_o, d;
   logic [3:0]  mux_sel_o;
   logic        comp_above_i, sample_o, analog_on_o, irq_o;
   int          errors = 0;
   int          num_checks = 0;
   always #2 clk_i = ~clk_i;
   sar_adc_sequencer u_sar_adc_sequencer (
      .clk_i        (clk_i),
      .rst_b_i      (rst_b_i),
      .addr_i       (addr_i),
      .wdata_i      (wdata_i),
      .wr_i         (wr_i),
      .rd_i         (rd_i),
      .rdata_o      (rdata_o),
      .comp_above_i (comp_above_i),
      .halt_mode_i  (halt_mode_i),
      .wait_mode_i  (wait_mode_i),
      .mux_sel_o    (mux_sel_o),
      .sample_o     (sample_o),
      .dac_code_o   (dac_code_o),
      .analog_on_o  (analog_on_o),
      .irq_o        (irq_o)
   );
   analog_front_model u_analog_front_model (.clk_i(clk_i), .mux_sel_i(mux_sel_o),
      .sample_i(sample_o), .dac_code_i(dac_code_o), .comp_above_o(comp_above_i));
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask
   // Bounded wait on the conversion-end interrupt
   task automatic wait_irq();
      for (int i = 0; i < 80; i++) begin
         @(posedge clk_i);
         #1;
         if (irq_o === 1'b1) break;
      end
      if (irq_o !== 1'b1) begin
         errors++;
         final_report();
      end
   endtask
   function automatic logic [7:0] lvl(input logic [3:0] c);
      return (c == 4'hf) ? 8'hff : (c == 4'h0) ? 8'h00 : {c, 4'h9};
   endfunction
   initial begin
      logic [3:0] chs [3] = '{4'h0, 4'h5, 4'hf};
      repeat (2) @(posedge clk_i);
      rst_b_i <= 1'b1;
      rd(RESULT_ADDR, d);
      chk("result", d, RESULT_RESET);
      rd(CTRL_ADDR, d);
      chk("ctrl", d, CTRL_RESET);
      rd(16'h0075, d);
      chk("unmapped", d, 8'h00);
      $display("test reset done");
      wr(IRQ_ENABLE_ADDR, 8'h01);
      foreach (chs[k]) begin
         wr(CTRL_ADDR, {4'h2, chs[k]});
         wr(IRQ_CLEAR_ADDR, 8'h03);
         wait_irq();
         chk("mux", {4'h0, mux_sel_o}, {4'h0, chs[k]});
         rd(CTRL_ADDR, d);
         chk("ctrl done", d, {4'ha, chs[k]});
         rd(RESULT_ADDR, d);
         chk("result", d, lvl(chs[k]));
         rd(CTRL_ADDR, d);
         chk("ctrl clear", d, {4'h2, chs[k]});
      end
      $display("test channels done");
      wr(RESULT_ADDR, 8'h55);
      rd(RESULT_ADDR, d);
      chk("result ro", d, 8'hff);
      wr(CTRL_ADDR, 8'h2f);
      rd(CTRL_ADDR, d);
      chk("ctrl mask", d, 8'h2f);
      wr(IRQ_CLEAR_ADDR, 8'h03);
      wr(CTRL_ADDR, 8'h25);
      rd(IRQ_STATUS_ADDR, d);
      chk("abort", {7'h0, d[1]}, 8'h01);
      wr(IRQ_ENABLE_ADDR, 8'h00);
      repeat (60) @(posedge clk_i);
      #1 chk("irq masked", {7'h0, irq_o}, 8'h00);
      rd(IRQ_STATUS_ADDR, d);
      chk("status", {7'h0, d[0]}, 8'h01);
      $display("test restart done");
      @(posedge clk_i);
      halt_mode_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      #1 chk("halt", {6'h0, analog_on_o, sample_o}, 8'h00);
      @(posedge clk_i);
      halt_mode_i <= 1'b0;
      wr(CTRL_ADDR, 8'h05);
      repeat (30) @(posedge clk_i);
      #1 chk("off", {6'h0, analog_on_o, sample_o}, 8'h00);
      rd(CTRL_ADDR, d);
      chk("off ctrl", d, 8'h05);
      $display("test power done");
      final_report();
   end
endmodule
